// ===== src/lcs_pkg.sv
package lcs_pkg;

   // ==========================================================
   // sizes
   localparam int NLINK = 8;
   localparam int GAP_W = 11;
   localparam int CHAN_W = 5;
   localparam int IDX_W = 10;

   // ==========================================================
   // register indices (byte address is four times the index)
   localparam logic [IDX_W-1:0] IDX_LINK_CFG = 10'h080;
   localparam logic [IDX_W-1:0] IDX_STATIC = 10'h0a0;
   localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 10'h0c0;
   localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h0c1;

   // ==========================================================
   // ext_link_config fields
   localparam int CFG_EN_BIT = 31;
   localparam int CFG_WIDE_BIT = 30;
   localparam int CFG_ERR_BIT = 27;
   localparam int CFG_ISSUED_BIT = 26;
   localparam int CFG_HELD_BIT = 25;
   localparam int CFG_GREETING_TOKEN_BIT = 24;
   localparam int CFG_RXRST_BIT = 23;
   localparam int CFG_SGAP_LSB = 11;
   localparam int CFG_TGAP_LSB = 0;
   localparam logic [GAP_W-1:0] GAP_RST = 11'h000;

   // ==========================================================
   // static_link_forwarding fields
   localparam int ST_EN_BIT = 31;
   localparam int ST_PROC_BIT = 8;
   localparam int ST_CHAN_LSB = 0;
   localparam logic [CHAN_W-1:0] ST_CHAN_RST = 5'h00;

   // ==========================================================
   // static register k serves link letter C,D,A,B,G,H,E,F (A=0)
   localparam logic [2:0] STATIC_REG_OF_LINK [0:NLINK-1] =
      '{3'h2, 3'h3, 3'h0, 3'h1, 3'h6, 3'h7, 3'h4, 3'h5};

   // interrupt status layout
   localparam int IRQ_ERR_LSB = 0;
   localparam int IRQ_CREDIT_LSB = 8;
   localparam int IRQ_W = 16;

endpackage

// ===== src/lcs_link.sv
`timescale 1ns/100ps
`default_nettype none

module lcs_link (
   input wire logic clk,
   input wire logic rst,
   input wire logic en,
   input wire logic [lcs_pkg::GAP_W-1:0] sym_gap,
   input wire logic [lcs_pkg::GAP_W-1:0] tok_gap,
   input wire logic greeting_token_wr,
   input wire logic rxrst_wr,
   input wire logic tx_sym_valid,
   input wire logic tx_sym_last,
   output logic tx_sym_ready,
   output logic tx_sym_strobe,
   output logic tx_greeting,
   input wire logic rx_sym,
   input wire logic rx_tok_end,
   input wire logic rx_illegal,
   input wire logic rx_overflow,
   input wire logic rx_credit,
   input wire logic rx_greeting,
   output logic rx_tok_start,
   output logic credit_held,
   output logic credit_issued,
   output logic rx_error,
   output logic err_event,
   output logic credit_event
);

   typedef enum logic [1:0] {LCS_OFF, LCS_GAP, LCS_READY} lcs_tx_t;

   lcs_tx_t st_q, st_d;
   logic [lcs_pkg::GAP_W:0] gap_q, gap_d;
   logic greet_pend_q, greet_pend_d;
   logic strobe_d, greet_d, start_d;
   logic held_d, issued_d, err_d, in_tok_q, in_tok_d;
   logic err_set, credit_set, send, greet_go;

   // ==========================================================
   // next state
   always_comb begin
      send = tx_sym_valid && (st_q == LCS_READY);
      greet_go = en && greet_pend_q && (st_q != LCS_OFF) &&
         (gap_q == '0) && !send;
      gap_d = gap_q;
      st_d = st_q;
      // idle gap is the programmed count plus one
      if (send) begin
         gap_d = tx_sym_last ? {1'b0, tok_gap} + 12'h001 :
            {1'b0, sym_gap} + 12'h001;
      end else if (greet_go) begin
         gap_d = {1'b0, tok_gap} + 12'h001;
      end else if (gap_q != '0) begin
         gap_d = gap_q - 12'h001;
      end
      greet_pend_d = greeting_token_wr || (greet_pend_q && !greet_go);
      // sending needs credit; the greeting goes first
      case (st_q)
         LCS_OFF: st_d = en ? LCS_GAP : LCS_OFF;
         LCS_GAP, LCS_READY: begin
            if (!en) begin
               st_d = LCS_OFF;
            end else if (gap_d == '0 && held_d && !greet_pend_d) begin
               st_d = LCS_READY;
            end else begin
               st_d = LCS_GAP;
            end
         end
         default: st_d = LCS_OFF;
      endcase
      strobe_d = send;
      greet_d = greet_go;
      // credit arrival beats a simultaneous greeting write
      credit_set = en && rx_credit;
      held_d = credit_set || (credit_held && en && !greeting_token_wr);
      issued_d = (en && rx_greeting) ||
         (credit_issued && en && !rxrst_wr);
      err_set = en && (rx_illegal || rx_overflow);
      err_d = err_set || (rx_error && !rxrst_wr);
      // receiver reset makes the next symbol open a token
      start_d = en && rx_sym && !in_tok_q && !rxrst_wr;
      if (rxrst_wr || !en) begin
         in_tok_d = 1'b0;
      end else if (rx_tok_end) begin
         in_tok_d = 1'b0;
      end else if (rx_sym) begin
         in_tok_d = 1'b1;
      end else begin
         in_tok_d = in_tok_q;
      end
   end

   // ==========================================================
   // registers
   always_ff @(posedge clk) begin
      if (rst) begin
         st_q <= LCS_OFF;
         gap_q <= '0;
         greet_pend_q <= 1'b0;
         tx_sym_ready <= 1'b0;
         tx_sym_strobe <= 1'b0;
         tx_greeting <= 1'b0;
         rx_tok_start <= 1'b0;
         credit_held <= 1'b0;
         credit_issued <= 1'b0;
         rx_error <= 1'b0;
         in_tok_q <= 1'b0;
         err_event <= 1'b0;
         credit_event <= 1'b0;
      end else begin
         st_q <= st_d;
         gap_q <= gap_d;
         greet_pend_q <= greet_pend_d;
         tx_sym_ready <= (st_d == LCS_READY);
         tx_sym_strobe <= strobe_d;
         tx_greeting <= greet_d;
         rx_tok_start <= start_d;
         credit_held <= held_d;
         credit_issued <= issued_d;
         rx_error <= err_d;
         in_tok_q <= in_tok_d;
         err_event <= err_set;
         credit_event <= credit_set && !credit_held;
      end
   end

endmodule

`default_nettype wire

// ===== src/lcs_top.sv
// Summary of operation
// - one link configuration register per external link 0..7, each alone.
// - config bit 31 enables the link when one, disables when zero.
// - link enable also hands shared pins to the link, not ports.
// - config bit 30 picks two-wire (0) or five-wire (1) width.
// - writing one to bit 24 clears send credit and sends greeting.
// - writing one to bit 23 resets receiver; next symbol starts token.
// - bit 26 shows credit issued to remote; bit 25 credit held.
// - bit 27 flags receive buffer overflow or illegal token code.
// - at least count+1 idle clocks between symbols and tokens.
// - static link forwards every packet to set channel end, no lookup.
// - static registers in order serve links C,D,A,B,G,H,E,F.
// - static bit 31 enables static forwarding, read/write, resets zero.
// - static bit 8 picks destination processor, resets zero.
// - static field 4:0 picks destination channel end, resets zero.
// - reserved config and static bits are read-only.
`timescale 1ns/100ps
`default_nettype none

module lcs_top (
   input wire logic clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output logic irq,
   input wire logic [7:0] tx_sym_valid,
   input wire logic [7:0] tx_sym_last,
   output logic [7:0] tx_sym_ready,
   output logic [7:0] tx_sym_strobe,
   output logic [7:0] tx_greeting,
   output logic [7:0] link_pin_select,
   output logic [7:0] link_wire_width,
   input wire logic [7:0] rx_sym,
   input wire logic [7:0] rx_tok_end,
   input wire logic [7:0] rx_illegal,
   input wire logic [7:0] rx_overflow,
   input wire logic [7:0] rx_credit,
   input wire logic [7:0] rx_greeting,
   output logic [7:0] rx_tok_start,
   input wire logic [7:0] rx_pkt_start,
   output logic [7:0] fwd_valid,
   output logic [7:0] fwd_proc,
   output logic [39:0] fwd_chan,
   output logic [7:0] route_req
);

   localparam int N = lcs_pkg::NLINK;
   localparam int GW = lcs_pkg::GAP_W;
   localparam int CW = lcs_pkg::CHAN_W;
   localparam int IW = lcs_pkg::IRQ_W;

   // ==========================================================
   // bus slave state
   logic take;
   logic rd_pend_q, rd_pend_d, wr_pend_q, wr_pend_d;
   logic [lcs_pkg::IDX_W-1:0] idx_q, idx_d;
   logic hreadyout_d;
   logic [31:0] hrdata_d, rdata;
   logic [31:0] cfg_word [0:N-1];
   logic [31:0] st_word [0:N-1];
   logic [N-1:0] cfg_wr, greeting_token_wr, rxrst_wr;
   logic [N-1:0] held, issued, rxerr, err_ev, cr_ev;
   // interrupt state
   logic [IW-1:0] stat_q, stat_d, mask_q, mask_d, events;
   logic irq_d;

   // hsize is accepted but only whole words are decoded
   always_comb begin
      take = hsel && htrans[1] && hready;
      rd_pend_d = take && !hwrite;
      wr_pend_d = take && hwrite;
      idx_d = take ? haddr[11:2] : idx_q;
      // one wait state on reads so data reflect a write just done
      hreadyout_d = !(take && !hwrite);
      // read data stand until the next read completes
      hrdata_d = rd_pend_q ? rdata : hrdata;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rd_pend_q <= 1'b0;
         wr_pend_q <= 1'b0;
         idx_q <= '0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h00000000;
      end else begin
         rd_pend_q <= rd_pend_d;
         wr_pend_q <= wr_pend_d;
         idx_q <= idx_d;
         hreadyout <= hreadyout_d;
         hresp <= 1'b0;
         hrdata <= hrdata_d;
      end
   end

   // ==========================================================
   // read multiplexer; unmapped words read as zero
   always_comb begin
      rdata = 32'h00000000;
      for (int k = 0; k < N; k++) begin
         if (idx_q == lcs_pkg::IDX_LINK_CFG + 10'(k)) begin
            rdata = cfg_word[k];
         end
         if (idx_q == lcs_pkg::IDX_STATIC + 10'(k)) begin
            rdata = st_word[k];
         end
      end
      if (idx_q == lcs_pkg::IDX_IRQ_STAT) begin
         rdata = {16'h0000, stat_q};
      end
      if (idx_q == lcs_pkg::IDX_IRQ_MASK) begin
         rdata = {16'h0000, mask_q};
      end
   end

   // ==========================================================
   // per-link configuration, static forwarding and link engine
   for (genvar i = 0; i < N; i++) begin : g_link
      localparam logic [lcs_pkg::IDX_W-1:0] CFG_IDX =
         lcs_pkg::IDX_LINK_CFG + 10'(i);
      localparam logic [lcs_pkg::IDX_W-1:0] ST_IDX =
         lcs_pkg::IDX_STATIC + 10'(lcs_pkg::STATIC_REG_OF_LINK[i]);
      logic en_q, en_d, wide_q, wide_d;
      logic [GW-1:0] sgap_q, sgap_d, tgap_q, tgap_d;
      logic sen_q, sen_d, proc_q, proc_d;
      logic [CW-1:0] chan_q, chan_d;
      logic st_wr;
      logic fv_d, rr_d;

      always_comb begin
         cfg_wr[i] = wr_pend_q && (idx_q == CFG_IDX);
         st_wr = wr_pend_q && (idx_q == ST_IDX);
         greeting_token_wr[i] = cfg_wr[i] && hwdata[lcs_pkg::CFG_GREETING_TOKEN_BIT];
         rxrst_wr[i] = cfg_wr[i] && hwdata[lcs_pkg::CFG_RXRST_BIT];
         en_d = en_q;
         wide_d = wide_q;
         sgap_d = sgap_q;
         tgap_d = tgap_q;
         // only defined fields are stored; reserved bits drop
         if (cfg_wr[i]) begin
            en_d = hwdata[lcs_pkg::CFG_EN_BIT];
            wide_d = hwdata[lcs_pkg::CFG_WIDE_BIT];
            sgap_d = hwdata[lcs_pkg::CFG_SGAP_LSB +: GW];
            tgap_d = hwdata[lcs_pkg::CFG_TGAP_LSB +: GW];
         end
         sen_d = sen_q;
         proc_d = proc_q;
         chan_d = chan_q;
         if (st_wr) begin
            sen_d = hwdata[lcs_pkg::ST_EN_BIT];
            proc_d = hwdata[lcs_pkg::ST_PROC_BIT];
            chan_d = hwdata[lcs_pkg::ST_CHAN_LSB +: CW];
         end
         // write-only bits and reserved bits read back as zero
         cfg_word[i] = {en_q, wide_q, 2'b00, rxerr[i], issued[i], held[i],
            3'b000, sgap_q, tgap_q};
         st_word[lcs_pkg::STATIC_REG_OF_LINK[i]] =
            {sen_q, 22'h000000, proc_q, 3'b000, chan_q};
         // static links bypass the routing lookup entirely
         fv_d = rx_pkt_start[i] && sen_q;
         rr_d = rx_pkt_start[i] && !sen_q;
      end

      always_ff @(posedge clk) begin
         if (rst) begin
            en_q <= 1'b0;
            wide_q <= 1'b0;
            sgap_q <= lcs_pkg::GAP_RST;
            tgap_q <= lcs_pkg::GAP_RST;
            sen_q <= 1'b0;
            proc_q <= 1'b0;
            chan_q <= lcs_pkg::ST_CHAN_RST;
            link_pin_select[i] <= 1'b0;
            link_wire_width[i] <= 1'b0;
            fwd_valid[i] <= 1'b0;
            fwd_proc[i] <= 1'b0;
            fwd_chan[i*CW +: CW] <= lcs_pkg::ST_CHAN_RST;
            route_req[i] <= 1'b0;
         end else begin
            en_q <= en_d;
            wide_q <= wide_d;
            sgap_q <= sgap_d;
            tgap_q <= tgap_d;
            sen_q <= sen_d;
            proc_q <= proc_d;
            chan_q <= chan_d;
            link_pin_select[i] <= en_d;
            link_wire_width[i] <= wide_d;
            fwd_valid[i] <= fv_d;
            fwd_proc[i] <= proc_q;
            fwd_chan[i*CW +: CW] <= chan_q;
            route_req[i] <= rr_d;
         end
      end

      lcs_link u_link (
         .clk(clk),
         .rst(rst),
         .en(en_q),
         .sym_gap(sgap_q),
         .tok_gap(tgap_q),
         .greeting_token_wr(greeting_token_wr[i]),
         .rxrst_wr(rxrst_wr[i]),
         .tx_sym_valid(tx_sym_valid[i]),
         .tx_sym_last(tx_sym_last[i]),
         .tx_sym_ready(tx_sym_ready[i]),
         .tx_sym_strobe(tx_sym_strobe[i]),
         .tx_greeting(tx_greeting[i]),
         .rx_sym(rx_sym[i]),
         .rx_tok_end(rx_tok_end[i]),
         .rx_illegal(rx_illegal[i]),
         .rx_overflow(rx_overflow[i]),
         .rx_credit(rx_credit[i]),
         .rx_greeting(rx_greeting[i]),
         .rx_tok_start(rx_tok_start[i]),
         .credit_held(held[i]),
         .credit_issued(issued[i]),
         .rx_error(rxerr[i]),
         .err_event(err_ev[i]),
         .credit_event(cr_ev[i])
      );
   end

   // ==========================================================
   // interrupts: sticky status, write one to clear, set wins
   always_comb begin
      events = '0;
      events[lcs_pkg::IRQ_ERR_LSB +: N] = err_ev;
      events[lcs_pkg::IRQ_CREDIT_LSB +: N] = cr_ev;
      stat_d = stat_q;
      mask_d = mask_q;
      if (wr_pend_q && idx_q == lcs_pkg::IDX_IRQ_STAT) begin
         stat_d = stat_q & ~hwdata[IW-1:0];
      end
      if (wr_pend_q && idx_q == lcs_pkg::IDX_IRQ_MASK) begin
         mask_d = hwdata[IW-1:0];
      end
      stat_d = stat_d | events;
      irq_d = |(stat_d & mask_d);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         stat_q <= '0;
         mask_q <= '0;
         irq <= 1'b0;
      end else begin
         stat_q <= stat_d;
         mask_q <= mask_d;
         irq <= irq_d;
      end
   end

endmodule

`default_nettype wire

// ===== verification/lcs_top_chk_sva.sv
`timescale 1ns/100ps
`default_nettype none
module lcs_top_chk (
   input wire logic clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic [7:0] tx_sym_ready,
   input wire logic [7:0] tx_sym_strobe,
   input wire logic [7:0] tx_greeting,
   input wire logic [7:0] link_pin_select,
   input wire logic [7:0] link_wire_width,
   input wire logic [7:0] rx_sym,
   input wire logic [7:0] rx_tok_start,
   input wire logic [7:0] rx_pkt_start,
   input wire logic [7:0] fwd_valid,
   input wire logic [7:0] route_req
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic take;
   assign take = hsel && htrans[1] && hready;
   // ======
   // bus and config
   chk_read_wait: assert property (
      take && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   chk_write_nowait: assert property (
      take && hwrite |=> hreadyout)
      else $error("write stalled");
   chk_cfg_by_write: assert property (
      $changed({link_pin_select, link_wire_width}) |->
      $past(take && hwrite, 2))
      else $error("link enable or width changed without write");
   // ======
   // link traffic
   chk_ready_needs_link: assert property (
      (tx_sym_ready & ~link_pin_select & ~$past(link_pin_select)) == 0)
      else $error("ready on disabled link");
   chk_greet_needs_link: assert property (
      (tx_greeting & ~link_pin_select & ~$past(link_pin_select)) == 0)
      else $error("greeting on disabled link");
   chk_strobe_spacing: assert property (
      (tx_sym_strobe & ($past(tx_sym_strobe) | tx_sym_ready)) == 0)
      else $error("symbols too close");
   chk_greet_single: assert property (
      (tx_greeting & $past(tx_greeting)) == 0)
      else $error("greeting longer than one cycle");
   chk_tok_start: assert property (
      (rx_tok_start & ~$past(rx_sym)) == 0)
      else $error("token start without symbol");
   chk_pkt_split: assert property (
      (fwd_valid | route_req) == $past(rx_pkt_start) &&
      (fwd_valid & route_req) == 0)
      else $error("packet not handled exactly once");
endmodule
`default_nettype wire

// ===== verification/lcs_remote.sv
`timescale 1ns/100ps
`default_nettype none
module lcs_remote #(
   parameter int DLY = 3
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] tx_greeting,
   output logic [7:0] rx_credit,
   output logic [7:0] rx_greeting
);
   // far switch answers a greeting some cycles later
   logic [7:0] pipe_q [0:DLY-1];
   always_ff @(posedge clk) begin
      if (rst) begin
         pipe_q <= '{default: 8'h00};
      end else begin
         pipe_q[0] <= tx_greeting;
         for (int i = 1; i < DLY; i++) begin
            pipe_q[i] <= pipe_q[i-1];
         end
      end
   end
   assign rx_credit = pipe_q[DLY-1];
   // greets back, so this end ends up having issued credit too
   assign rx_greeting = pipe_q[DLY-1];
endmodule
`default_nettype wire

// ===== verification/tb_lcs_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_lcs_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic [11:0] haddr = 12'h000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   wire logic hready;
   logic hreadyout, hresp, irq;
   logic [31:0] hrdata, rd;
   logic [7:0] tx_valid = 8'h00;
   logic [7:0] tx_last = 8'h00;
   // rx pulses: symbol, illegal, overflow, packet start
   logic [7:0] pin [0:3] = '{default: 8'h00};
   logic [7:0] tx_sym_ready, tx_sym_strobe, tx_greeting, rx_tok_start;
   logic [7:0] link_pin_select, link_wire_width, fwd_valid, fwd_proc;
   logic [7:0] route_req, rx_credit, rx_greeting;
   logic [39:0] fwd_chan;
   int errors = 0;
   int checked = 0;
   int cyc = 0;
   int last_s = 0;
   int gap_s = 0;
   int n_s = 0;
   int n_g = 0;
   int k;
   int lk [0:7] = '{2, 3, 0, 1, 6, 7, 4, 5};
   always #12.5 clk = ~clk;
   assign hready = hreadyout;
   lcs_top lcs_top_inst (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .irq(irq), .tx_sym_valid(tx_valid),
      .tx_sym_last(tx_last), .tx_sym_ready(tx_sym_ready),
      .tx_sym_strobe(tx_sym_strobe), .tx_greeting(tx_greeting),
      .link_pin_select(link_pin_select), .link_wire_width(link_wire_width),
      .rx_sym(pin[0]), .rx_tok_end(8'h00), .rx_illegal(pin[1]),
      .rx_overflow(pin[2]), .rx_credit(rx_credit),
      .rx_greeting(rx_greeting), .rx_tok_start(rx_tok_start),
      .rx_pkt_start(pin[3]), .fwd_valid(fwd_valid), .fwd_proc(fwd_proc),
      .fwd_chan(fwd_chan), .route_req(route_req));
   lcs_remote #(.DLY(3)) lcs_remote_inst (.clk(clk), .rst(rst),
      .tx_greeting(tx_greeting), .rx_credit(rx_credit),
      .rx_greeting(rx_greeting));
   always @(posedge clk) begin
      cyc++;
      if (tx_sym_strobe[0] === 1'b1) begin
         gap_s = cyc - last_s;
         last_s = cyc;
         n_s++;
      end
      if (tx_greeting[0] === 1'b1) n_g++;
   end
   // ======
   // tasks
   task automatic conclude;
      $display("checks %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      checked++;
      if (g !== e) begin
         errors++;
         $display("FAIL %s exp %h got %h", nm, e, g);
      end
   endtask
   // one AHB single transfer; returns read data in rd
   task automatic bus(input logic [11:0] a, input logic w,
      input logic [31:0] wd);
      int n;
      n = 0;
      haddr <= a;
      hwrite <= w;
      hsel <= 1'b1;
      htrans <= 2'h2;
      do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 99);
      rd = hrdata;
      if (n >= 99) begin
         errors++;
         conclude();
      end
   endtask
   task automatic rdc(input string nm, input logic [11:0] a,
      input logic [31:0] e);
      bus(a, 1'b0, 32'h0000_0000);
      chk(nm, e, rd);
      chk("hresp", 32'h0, 32'(hresp));
   endtask
   task automatic pulse(input int i, input logic [7:0] v);
      @(posedge clk);
      pin[i] <= v;
      @(posedge clk);
      pin[i] <= 8'h00;
      #1;
   endtask
   task automatic wait_cnt(ref int v, input int t);
      int n;
      n = 0;
      while (v < t && n < 200) begin
         @(posedge clk);
         n++;
      end
      if (v < t) begin
         errors++;
         conclude();
      end
   endtask
   // ======
   // scenarios
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      for (int n = 0; n < 8; n++) begin
         rdc("cfg reset", 12'(12'h200 + 4*n), 32'h0);
         rdc("static reset", 12'(12'h280 + 4*n), 32'h0);
         bus(12'(12'h200 + 4*n), 1'b1, 32'h7e7f_ffff);
         rdc("cfg rw", 12'(12'h200 + 4*n), 32'h403f_ffff);
         bus(12'(12'h280 + 4*n), 1'b1, 32'h7fff_fee0);
         rdc("static rsv", 12'(12'h280 + 4*n), 32'h0);
      end
      chk("width", 32'h0000_00ff, 32'(link_wire_width));
      chk("pins", 32'h0, 32'(link_pin_select));
      bus(12'h3fc, 1'b1, 32'hffff_ffff);
      rdc("unmapped", 12'h3fc, 32'h0);
      for (int n = 0; n < 8; n++)
         bus(12'(12'h280 + 4*n), 1'b1, (n % 2 ? 32'h8000_0100 : 0) | n);
      for (int n = 0; n < 8; n++) begin
         k = (n % 2 ? 32'h8000_0100 : 0) | n;
         rdc("static rw", 12'(12'h280 + 4*n), k);
         chk("chan", n, 32'(fwd_chan[5*lk[n] +: 5]));
         chk("proc", n % 2, 32'(fwd_proc[lk[n]]));
      end
      pulse(3, 8'hff);
      chk("fwd", 32'h0000_00aa, 32'(fwd_valid));
      chk("route", 32'h0000_0055, 32'(route_req));
      bus(12'h200, 1'b1, 32'h8100_1003);
      wait_cnt(n_g, 1);
      repeat (6) @(posedge clk);
      chk("greetings", 1, n_g);
      rdc("credit", 12'h200, 32'h8600_1003);
      rdc("irq status", 12'h300, 32'h0000_0100);
      chk("irq masked", 0, 32'(irq));
      bus(12'h304, 1'b1, 32'h0000_0100);
      @(posedge clk);
      #1;
      chk("irq on", 1, 32'(irq));
      bus(12'h300, 1'b1, 32'h0000_0100);
      @(posedge clk);
      #1;
      chk("irq off", 0, 32'(irq));
      tx_valid <= 8'h01;
      k = n_s;
      wait_cnt(n_s, k + 3);
      chk("symbol spacing", 4, gap_s);
      tx_last <= 8'h01;
      k = n_s;
      wait_cnt(n_s, k + 3);
      chk("token spacing", 5, gap_s);
      tx_valid <= 8'h00;
      bus(12'h204, 1'b1, 32'h8000_0000);
      pulse(2, 8'h02);
      rdc("overflow", 12'h204, 32'h8800_0000);
      rdc("err status", 12'h300, 32'h0000_0002);
      bus(12'h204, 1'b1, 32'h8080_0000);
      rdc("rx reset", 12'h204, 32'h8000_0000);
      pulse(1, 8'h02);
      rdc("illegal", 12'h204, 32'h8800_0000);
      pulse(0, 8'h02);
      chk("token start", 32'h0000_0002, 32'(rx_tok_start));
      bus(12'h200, 1'b1, 32'h0);
      rdc("disable", 12'h200, 32'h0);
      chk("pins on", 32'h0000_0002, 32'(link_pin_select));
      conclude();
   end
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      conclude();
   end
endmodule
bind lcs_top lcs_top_chk lcs_top_chk_inst (.clk(clk), .rst(rst),
   .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hreadyout(hreadyout), .tx_sym_ready(tx_sym_ready),
   .tx_sym_strobe(tx_sym_strobe), .tx_greeting(tx_greeting),
   .link_pin_select(link_pin_select), .link_wire_width(link_wire_width),
   .rx_sym(rx_sym), .rx_tok_start(rx_tok_start),
   .rx_pkt_start(rx_pkt_start), .fwd_valid(fwd_valid),
   .route_req(route_req));
`default_nettype wire
